//--- design/egx_pkg.sv
// Package: constants and types for the encrypted guest exit control block
package egx_pkg;
    // ------------------------------------------------------------
    // Exception and register constants
    // ------------------------------------------------------------
    localparam logic [7:0] COMM_EXC_VECTOR = 8'h1D; // Vector 29
    localparam logic [31:0] LOCATOR_MSR_ADDR = 32'hC0010130; // Locator register index
    localparam logic [63:0] LOCATOR_RESET = 64'h0; // Locator reset value
    localparam logic [11:0] VM_CONTROL_BLOCK_LOCATOR_OFS = 12'h0A0; // Locator save slot
    localparam logic [11:0] VM_CONTROL_BLOCK_SAVE_PTR_OFS = 12'h108; // Save-area pointer slot
    localparam logic [11:0] VM_CONTROL_BLOCK_LEGACY_SAVE_OFS = 12'h400; // Unused for encrypted guests
    localparam logic [11:0] VM_CONTROL_BLOCK_EXIT_RAX_OFS = 12'h110; // Exit parameter value slot
    localparam logic [11:0] VM_CONTROL_BLOCK_EXIT_CPL_OFS = 12'h118; // Exit parameter level slot
    localparam int EXIT_PARAM_BIT = 10; // Feature field bit
    localparam int CLEAN_LO = 5; // Clean bits ignored, low end
    localparam int CLEAN_HI = 10; // Clean bits ignored, high end
    localparam int MACHINE_CHECK_REDIRECT_BIT_BIT = 0; // Redirect bit position, arbitrary choice
    // ------------------------------------------------------------
    // Exit codes
    // ------------------------------------------------------------
    localparam logic [63:0] EC_MC = 64'h52;
    localparam logic [63:0] EC_INTR = 64'h60;
    localparam logic [63:0] EC_NMI = 64'h61;
    localparam logic [63:0] EC_SMI = 64'h62;
    localparam logic [63:0] EC_INIT = 64'h63;
    localparam logic [63:0] EC_VINTR = 64'h64;
    localparam logic [63:0] EC_PAUSE = 64'h77;
    localparam logic [63:0] EC_HLT = 64'h78;
    localparam logic [63:0] EC_SHUTDOWN = 64'h7F;
    localparam logic [63:0] EC_FEAT_TRAP = 64'h8F;
    localparam logic [63:0] EC_CR_TRAP_LO = 64'h90;
    localparam logic [63:0] EC_CR_TRAP_HI = 64'h9F;
    localparam logic [63:0] EC_BUSLOCK = 64'hA5;
    localparam logic [63:0] EC_IDLE_HLT = 64'hA6;
    localparam logic [63:0] EC_NPF = 64'h400;
    localparam logic [63:0] EC_GUEST_EXIT = 64'h403;
    localparam logic [63:0] EC_HCALL = 64'h81; // Plain hypervisor call code
    localparam logic [63:0] EC_INVALID = 64'hFFFFFFFFFFFFFFFF; // Minus one
    localparam logic [7:0] VEC_BP = 8'h03; // Vector 3
    localparam logic [7:0] VEC_OF = 8'h04; // Vector 4
    localparam logic [2:0] INJ_SOFT_INT = 3'h4; // Software interrupt type
    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        EGX_IDLE = 4'b0000,
        EGX_E_CSUM = 4'b0001,
        EGX_E_XLOAD = 4'b0010,
        EGX_E_GPR = 4'b0011,
        EGX_E_FPU = 4'b0100,
        EGX_GUEST = 4'b0101,
        EGX_X_XSAVE = 4'b0110,
        EGX_X_GPRFPU = 4'b0111,
        EGX_X_CSUM = 4'b1000,
        EGX_X_HLOAD = 4'b1001,
        EGX_X_HGPR = 4'b1010,
        EGX_X_FPRST = 4'b1011,
        EGX_X_DONE = 4'b1100
    } egx_state_type;
    // Step commands toward the memory engine
    typedef enum logic [3:0] {
        EGX_OP_NONE = 4'b0000,
        EGX_OP_CSUM_CHK = 4'b0001,
        EGX_OP_XLOAD_G = 4'b0010,
        EGX_OP_GPR_LD = 4'b0011,
        EGX_OP_FPU_LD = 4'b0100,
        EGX_OP_XSAVE_G = 4'b0101,
        EGX_OP_GPRFPU_SV = 4'b0110,
        EGX_OP_CSUM_ST = 4'b0111,
        EGX_OP_XLOAD_H = 4'b1000,
        EGX_OP_HGPR_LD = 4'b1001,
        EGX_OP_FPU_RST = 4'b1010
    } egx_op_type;
endpackage : egx_pkg

//--- design/egx_classify_if.sv
// Interface: exit classification request and answer
`timescale 1ns/100ps
`default_nettype none
interface egx_classify_if;
    logic [63:0] code; // Exit code to classify
    logic automatic_exit; // Code is on the automatic list
    logic advance_ip; // Hardware advances instruction pointer
    modport req (output code, input automatic_exit, input advance_ip);
    modport rsp (input code, output automatic_exit, output advance_ip);
endinterface : egx_classify_if
`default_nettype wire

//--- design/egx_classify.sv
// Module: combinational exit-code classifier
`timescale 1ns/100ps
`default_nettype none
module egx_classify (
    egx_classify_if.rsp cls
);
    // ------------------------------------------------------------
    // Automatic exit table lookup
    // ------------------------------------------------------------
    always_comb begin
        cls.automatic_exit = 1'b0;
        cls.advance_ip = 1'b0;
        // Instruction exits advance the pointer
        if (cls.code == egx_pkg::EC_PAUSE || cls.code == egx_pkg::EC_HLT ||
            cls.code == egx_pkg::EC_FEAT_TRAP || cls.code == egx_pkg::EC_IDLE_HLT ||
            cls.code == egx_pkg::EC_GUEST_EXIT ||
            (cls.code >= egx_pkg::EC_CR_TRAP_LO && cls.code <= egx_pkg::EC_CR_TRAP_HI)) begin
            cls.automatic_exit = 1'b1;
            cls.advance_ip = 1'b1;
        end else if (cls.code == egx_pkg::EC_MC || cls.code == egx_pkg::EC_INTR ||
            cls.code == egx_pkg::EC_NMI || cls.code == egx_pkg::EC_SMI ||
            cls.code == egx_pkg::EC_INIT || cls.code == egx_pkg::EC_VINTR ||
            cls.code == egx_pkg::EC_SHUTDOWN || cls.code == egx_pkg::EC_BUSLOCK ||
            cls.code == egx_pkg::EC_NPF || cls.code[63:2] == 62'h3FFFFFFFFFFFFFFF) begin
            cls.automatic_exit = 1'b1;
        end
    end
endmodule : egx_classify
`default_nettype wire

//--- design/egx_exit_ctrl.sv
// Module: encrypted guest entry, exit and exception control sequencer
`timescale 1ns/100ps
`default_nettype none
module egx_exit_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    // Entry request from the world-switch front end
    input wire logic entry_req_i,
    input wire logic encrypted_i,
    input wire logic [63:0] feature_field_i,
    input wire logic [63:0] save_ptr_i,
    input wire logic [31:0] clean_bits_i,
    input wire logic inject_valid_i,
    input wire logic [2:0] inject_type_i,
    input wire logic [7:0] inject_vector_i,
    input wire logic [63:0] vm_control_block_locator_i,
    // Step engine handshake
    output logic [3:0] step_op_o,
    output logic [63:0] step_addr_o,
    input wire logic step_done_i,
    input wire logic step_fault_i,
    input wire logic csum_ok_i,
    // Guest events
    input wire logic exit_event_i,
    input wire logic [63:0] exit_code_i,
    input wire logic guest_exit_insn_i,
    input wire logic [63:0] guest_rax_i,
    input wire logic [1:0] guest_cpl_i,
    input wire logic reg_write_trap_i,
    input wire logic [63:0] reg_new_value_i,
    input wire logic feat_write_i,
    input wire logic [63:0] feat_write_value_i,
    input wire logic smi_i,
    input wire logic smi_is_mc_i,
    input wire logic gi_enable_i,
    // Locator register access
    input wire logic msr_rd_i,
    input wire logic msr_wr_i,
    input wire logic [31:0] msr_addr_i,
    input wire logic [63:0] msr_wdata_i,
    output logic [63:0] msr_rdata_o,
    output logic gp_fault_o,
    // Results
    output logic guest_mode_o,
    output logic comm_exc_o,
    output logic [7:0] comm_exc_vector_o,
    output logic [63:0] comm_exc_error_o,
    output logic hcall_o,
    output logic vmexit_o,
    output logic [63:0] vmexit_code_o,
    output logic [63:0] exit_info_first_o,
    output logic advance_ip_o,
    output logic param_wr_o,
    output logic [63:0] param_rax_o,
    output logic [1:0] param_cpl_o,
    output logic [63:0] vm_control_block_locator_o,
    output logic full_reload_o,
    output logic feat_wr_o,
    output logic [63:0] feat_wr_value_o,
    output logic feat_wr_mask_enable_o,
    output logic smi_pending_o,
    output logic smi_service_o
);
    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        egx_pkg::egx_state_type st; // Sequencer state
        logic enc; // Running guest is encrypted
        logic [63:0] locator; // Communication page locator
        logic [63:0] save_ptr; // Host-physical save area pointer
        logic [63:0] code; // Pending exit code
        logic [63:0] info1; // Pending first info field
        logic adv; // Pending pointer advance
        logic smi_pend; // SMI waiting for interrupts
        logic smi_svc; // Service pulse
        logic exc; // Exception pulse
        logic [63:0] exc_err; // Exception error code
        logic hcall; // Hypervisor call pulse
        logic vmexit; // Exit pulse
        logic [63:0] vcode; // Reported exit code
        logic [63:0] vinfo; // Reported info field
        logic vadv; // Reported advance
        logic pwr; // Parameter write pulse
        logic [63:0] prax; // Parameter value
        logic [1:0] pcpl; // Parameter level
        logic gp; // Fault pulse
        logic [63:0] rdata; // Read data
        logic reload; // Full reload marker
        logic fwr; // Feature write pulse
        logic [63:0] fval; // Feature value
    } egx_ctrl_type;

    egx_ctrl_type s_q;
    egx_ctrl_type s_d;
    egx_classify_if cls_if ();

    // Classifier for the incoming exit code
    egx_classify u_classify (
        .cls(cls_if)
    );
    assign cls_if.code = exit_code_i;

    // Injection forbidden in encrypted guests
    function automatic logic bad_inject(input logic v, input logic [2:0] t,
                                        input logic [7:0] vec);
        bad_inject = v && (t == egx_pkg::INJ_SOFT_INT ||
                           vec == egx_pkg::VEC_BP || vec == egx_pkg::VEC_OF);
    endfunction : bad_inject

    // Start an exit sequence with code, info and advance
    function automatic egx_ctrl_type begin_exit(input egx_ctrl_type x, input logic [63:0] c,
                                                input logic [63:0] i, input logic a);
        egx_ctrl_type y;
        y = x;
        y.code = c;
        y.info1 = i;
        y.adv = a;
        y.st = egx_pkg::EGX_X_XSAVE;
        begin_exit = y;
    endfunction : begin_exit

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.smi_svc = 1'b0;
        s_d.exc = 1'b0;
        s_d.hcall = 1'b0;
        s_d.vmexit = 1'b0;
        s_d.pwr = 1'b0;
        s_d.gp = 1'b0;
        s_d.fwr = 1'b0;
        // SMI latch: set wins over service
        if (s_q.smi_pend && gi_enable_i && s_q.st == egx_pkg::EGX_IDLE) begin
            s_d.smi_pend = 1'b0;
            s_d.smi_svc = 1'b1;
        end
        // Locator access, guest mode only
        if ((msr_rd_i || msr_wr_i) && msr_addr_i == egx_pkg::LOCATOR_MSR_ADDR) begin
            if (s_q.st != egx_pkg::EGX_GUEST) begin
                s_d.gp = 1'b1;
            end else if (msr_wr_i) begin
                s_d.locator = msr_wdata_i;
            end else begin
                s_d.rdata = s_q.locator;
            end
        end
        case (s_q.st)
            egx_pkg::EGX_IDLE: begin
                if (entry_req_i) begin
                    s_d.enc = encrypted_i;
                    s_d.locator = vm_control_block_locator_i;
                    s_d.save_ptr = save_ptr_i;
                    // Encrypted guests mark a full host state reload; plain guests leave the rest to the hypervisor
                    s_d.reload = encrypted_i;
                    if (!encrypted_i) begin
                        s_d.st = egx_pkg::EGX_GUEST;
                    end else if (bad_inject(inject_valid_i, inject_type_i, inject_vector_i)) begin
                        s_d.vmexit = 1'b1;
                        s_d.vcode = egx_pkg::EC_INVALID;
                        s_d.vinfo = 64'h0;
                        s_d.vadv = 1'b0;
                    end else begin
                        s_d.st = egx_pkg::EGX_E_CSUM;
                    end
                end
            end
            egx_pkg::EGX_E_CSUM, egx_pkg::EGX_E_XLOAD, egx_pkg::EGX_E_GPR,
            egx_pkg::EGX_E_FPU: begin
                if (step_fault_i || (s_q.st == egx_pkg::EGX_E_CSUM && step_done_i && !csum_ok_i)) begin
                    s_d.st = egx_pkg::EGX_IDLE;
                    s_d.vmexit = 1'b1;
                    s_d.vcode = egx_pkg::EC_INVALID;
                    s_d.vinfo = 64'h0;
                    s_d.vadv = 1'b0;
                end else if (step_done_i) begin
                    s_d.st = egx_pkg::egx_state_type'(4'(s_q.st + 4'h1));
                end
            end
            egx_pkg::EGX_GUEST: begin
                // Whole value passes; feat_wr_mask_enable_o asks for the enable bit mask in encrypted guests
                if (feat_write_i) begin
                    s_d.fwr = 1'b1;
                    s_d.fval = feat_write_value_i;
                end
                if (guest_exit_insn_i && !s_q.enc) begin
                    s_d.hcall = 1'b1;
                    if (exit_event_i && exit_code_i == egx_pkg::EC_HCALL) begin
                        s_d.st = egx_pkg::EGX_IDLE;
                        s_d.vmexit = 1'b1;
                        s_d.vcode = egx_pkg::EC_HCALL;
                        s_d.vinfo = 64'h0;
                        s_d.vadv = 1'b0;
                    end
                end else if (s_q.enc && smi_i) begin
                    // Forced regardless of intercept
                    s_d.smi_pend = 1'b1;
                    s_d = begin_exit(s_d, egx_pkg::EC_SMI,
                        {63'h0, smi_is_mc_i}, 1'b0);
                end else if (s_q.enc && guest_exit_insn_i) begin
                    s_d = begin_exit(s_d, egx_pkg::EC_GUEST_EXIT, 64'h0, 1'b1);
                    if (feature_field_i[egx_pkg::EXIT_PARAM_BIT]) begin
                        s_d.pwr = 1'b1;
                        s_d.prax = guest_rax_i;
                        s_d.pcpl = guest_cpl_i;
                    end
                end else if (s_q.enc && reg_write_trap_i) begin
                    // Write already retired; value travels in info field
                    s_d = begin_exit(s_d, exit_code_i, reg_new_value_i, 1'b1);
                end else if (exit_event_i) begin
                    if (!s_q.enc) begin
                        s_d.st = egx_pkg::EGX_IDLE;
                        s_d.vmexit = 1'b1;
                        s_d.vcode = exit_code_i;
                        s_d.vinfo = 64'h0;
                        s_d.vadv = 1'b0;
                    end else if (cls_if.automatic_exit) begin
                        s_d = begin_exit(s_d, exit_code_i, 64'h0, cls_if.advance_ip);
                    end else begin
                        s_d.exc = 1'b1;
                        s_d.exc_err = exit_code_i;
                    end
                end
            end
            egx_pkg::EGX_X_XSAVE, egx_pkg::EGX_X_GPRFPU, egx_pkg::EGX_X_CSUM,
            egx_pkg::EGX_X_HLOAD, egx_pkg::EGX_X_HGPR, egx_pkg::EGX_X_FPRST: begin
                if (step_done_i) begin
                    s_d.st = egx_pkg::egx_state_type'(4'(s_q.st + 4'h1));
                end
            end
            egx_pkg::EGX_X_DONE: begin
                s_d.st = egx_pkg::EGX_IDLE;
                s_d.vmexit = 1'b1;
                s_d.vcode = s_q.code;
                s_d.vinfo = s_q.info1;
                s_d.vadv = s_q.adv;
                s_d.reload = 1'b0;
            end
            default: begin
                s_d.st = egx_pkg::EGX_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= egx_pkg::EGX_IDLE;
            s_q.locator <= egx_pkg::LOCATOR_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Step command decode
    // ------------------------------------------------------------
    always_comb begin
        case (s_q.st)
            egx_pkg::EGX_E_CSUM: step_op_o = egx_pkg::EGX_OP_CSUM_CHK;
            egx_pkg::EGX_E_XLOAD: step_op_o = egx_pkg::EGX_OP_XLOAD_G;
            egx_pkg::EGX_E_GPR: step_op_o = egx_pkg::EGX_OP_GPR_LD;
            egx_pkg::EGX_E_FPU: step_op_o = egx_pkg::EGX_OP_FPU_LD;
            egx_pkg::EGX_X_XSAVE: step_op_o = egx_pkg::EGX_OP_XSAVE_G;
            egx_pkg::EGX_X_GPRFPU: step_op_o = egx_pkg::EGX_OP_GPRFPU_SV;
            egx_pkg::EGX_X_CSUM: step_op_o = egx_pkg::EGX_OP_CSUM_ST;
            egx_pkg::EGX_X_HLOAD: step_op_o = egx_pkg::EGX_OP_XLOAD_H;
            egx_pkg::EGX_X_HGPR: step_op_o = egx_pkg::EGX_OP_HGPR_LD;
            egx_pkg::EGX_X_FPRST: step_op_o = egx_pkg::EGX_OP_FPU_RST;
            default: step_op_o = egx_pkg::EGX_OP_NONE;
        endcase
    end

    // Save area always via pointer, encrypted key implied
    assign step_addr_o = s_q.save_ptr;
    assign msr_rdata_o = s_q.rdata;
    assign gp_fault_o = s_q.gp;
    assign guest_mode_o = (s_q.st == egx_pkg::EGX_GUEST);
    assign comm_exc_o = s_q.exc;
    assign comm_exc_vector_o = egx_pkg::COMM_EXC_VECTOR;
    assign comm_exc_error_o = s_q.exc_err;
    assign hcall_o = s_q.hcall;
    assign vmexit_o = s_q.vmexit;
    assign vmexit_code_o = s_q.vcode;
    assign exit_info_first_o = s_q.vinfo;
    assign advance_ip_o = s_q.vadv;
    assign param_wr_o = s_q.pwr;
    assign param_rax_o = s_q.prax;
    assign param_cpl_o = s_q.pcpl;
    assign vm_control_block_locator_o = s_q.locator;
    assign full_reload_o = s_q.reload;
    assign feat_wr_o = s_q.fwr;
    assign feat_wr_value_o = s_q.fval;
    assign feat_wr_mask_enable_o = s_q.enc;
    assign smi_pending_o = s_q.smi_pend;
    assign smi_service_o = s_q.smi_svc;
endmodule : egx_exit_ctrl
`default_nettype wire

//--- verif/egx_exit_ctrl_asserts.sv
// Checker: port-level properties of the encrypted guest exit controller
`timescale 1ns/100ps
`default_nettype none
module egx_exit_ctrl_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic entry_req_i,
    input wire logic encrypted_i,
    input wire logic exit_event_i,
    input wire logic [63:0] exit_code_i,
    input wire logic guest_exit_insn_i,
    input wire logic [63:0] guest_rax_i,
    input wire logic [1:0] guest_cpl_i,
    input wire logic smi_i,
    input wire logic reg_write_trap_i,
    input wire logic msr_rd_i,
    input wire logic msr_wr_i,
    input wire logic [31:0] msr_addr_i,
    input wire logic [3:0] step_op_o,
    input wire logic step_done_i,
    input wire logic step_fault_i,
    input wire logic csum_ok_i,
    input wire logic guest_mode_o,
    input wire logic gp_fault_o,
    input wire logic comm_exc_o,
    input wire logic [7:0] comm_exc_vector_o,
    input wire logic [63:0] comm_exc_error_o,
    input wire logic hcall_o,
    input wire logic param_wr_o,
    input wire logic [63:0] param_rax_o,
    input wire logic [1:0] param_cpl_o,
    input wire logic vmexit_o,
    input wire logic [63:0] vmexit_code_o,
    input wire logic advance_ip_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Mode of the last guest entered
    logic enc_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) enc_q <= 1'b0;
        else if (entry_req_i && !guest_mode_o) enc_q <= encrypted_i;
    end
    property p_exc_code; comm_exc_o |-> comm_exc_vector_o == 8'h1D
        && comm_exc_error_o == $past(exit_code_i); endproperty
    a_exc_code: assert property (p_exc_code) else $error("exception vector or code");
    property p_nae; guest_mode_o && enc_q && exit_event_i && exit_code_i == 64'h7B
        && !guest_exit_insn_i && !smi_i && !reg_write_trap_i |=> comm_exc_o; endproperty
    a_nae: assert property (p_nae) else $error("no exception on exit event");
    property p_param; param_wr_o |-> param_rax_o == $past(guest_rax_i)
        && param_cpl_o == $past(guest_cpl_i); endproperty
    a_param: assert property (p_param) else $error("parameter values wrong");
    property p_gp; (msr_rd_i || msr_wr_i) && msr_addr_i == 32'hC0010130 && !guest_mode_o
        |=> gp_fault_o; endproperty
    a_gp: assert property (p_gp) else $error("host access not faulted");
    property p_hcall; hcall_o |-> $past(guest_exit_insn_i) && !$past(enc_q); endproperty
    a_hcall: assert property (p_hcall) else $error("call without cause");
    property p_entry; step_op_o == 4'h1 && step_done_i && csum_ok_i && !step_fault_i
        |=> step_op_o == 4'h2; endproperty
    a_entry: assert property (p_entry) else $error("entry step order");
    property p_exit; step_op_o == 4'h5 && step_done_i && !step_fault_i
        |=> step_op_o == 4'h6; endproperty
    a_exit: assert property (p_exit) else $error("exit step order");
    property p_adv; vmexit_o && vmexit_code_o == 64'h403 |-> advance_ip_o; endproperty
    a_adv: assert property (p_adv) else $error("pointer not advanced");
endmodule : egx_exit_ctrl_asserts
bind egx_exit_ctrl egx_exit_ctrl_asserts u_egx_exit_ctrl_asserts (.*);
`default_nettype wire

//--- verif/egx_testbench.sv
// Testbench: directed scenarios for the encrypted guest exit controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_i = 0, rst_i = 1, entry_req_i = 0, encrypted_i = 0, inject_valid_i = 0;
    logic step_done_i = 0, step_fault_i = 0, csum_ok_i = 0, exit_event_i = 0, smi_i = 0;
    logic guest_exit_insn_i = 0, reg_write_trap_i = 0, feat_write_i = 0, smi_is_mc_i = 0;
    logic gi_enable_i = 0, msr_rd_i = 0, msr_wr_i = 0;
    logic [63:0] feature_field_i = 64'h400, save_ptr_i = 64'h7000, vm_control_block_locator_i = 64'h3000;
    logic [63:0] exit_code_i = '0, guest_rax_i = '0, reg_new_value_i = '0, msr_wdata_i = '0;
    logic [63:0] feat_write_value_i = '0;
    logic [31:0] clean_bits_i = 32'h7E0, msr_addr_i = 32'hC0010130;
    logic [2:0] inject_type_i = '0;
    logic [7:0] inject_vector_i = '0, comm_exc_vector_o;
    logic [1:0] guest_cpl_i = '0, param_cpl_o;
    logic [3:0] step_op_o;
    logic [63:0] step_addr_o, msr_rdata_o, comm_exc_error_o, vmexit_code_o, exit_info_first_o;
    logic [63:0] param_rax_o, vm_control_block_locator_o, feat_wr_value_o;
    logic gp_fault_o, guest_mode_o, comm_exc_o, hcall_o, vmexit_o, advance_ip_o, param_wr_o;
    logic full_reload_o, feat_wr_o, feat_wr_mask_enable_o, smi_pending_o, smi_service_o;
    int num_errors = 0, comparisons = 0, cycles = 0;
    logic [3:0] ops[$]; // Steps requested of the engine
    egx_exit_ctrl u_egx_exit_ctrl (.*);
    always #25 clk_i = ~clk_i;
    // Hang guard: whole run needs well under a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            finish_test;
        end
    end
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Ends all one-cycle requests, then waits for settled outputs
    task drop;
        @(posedge clk_i);
        {exit_event_i, guest_exit_insn_i, reg_write_trap_i, feat_write_i, smi_i} <= '0;
        {smi_is_mc_i, gi_enable_i, msr_rd_i, msr_wr_i} <= '0;
        @(negedge clk_i);
    endtask : drop
    // Engine model: answers steps until guest start (g) or an exit
    task serve(input logic ok, input logic flt, input logic g);
        ops = {};
        for (int i = 0; i < 40; i++) begin
            @(negedge clk_i);
            if (vmexit_o || (g && guest_mode_o)) break;
            if (step_op_o != 4'h0) begin
                ops.push_back(step_op_o);
                @(posedge clk_i);
                {step_done_i, csum_ok_i, step_fault_i} <= {1'b1, ok, flt};
                @(posedge clk_i);
                {step_done_i, step_fault_i} <= 2'b00;
            end
        end
    endtask : serve
    // exp: exit code, or zero if the guest must start
    task enter(input logic enc, ok, flt, input logic [2:0] typ, input logic [7:0] vec,
               input logic [63:0] exp);
        @(posedge clk_i);
        {entry_req_i, encrypted_i, inject_valid_i} <= {1'b1, enc, typ != 3'h0};
        {inject_type_i, inject_vector_i} <= {typ, vec};
        @(posedge clk_i);
        entry_req_i <= 1'b0;
        serve(ok, flt, 1'b1);
        check("guest_mode", guest_mode_o, exp == '0);
        if (exp != '0) check("entry_exit", vmexit_code_o, exp);
    endtask : enter
    task msr(input logic wr, input logic [63:0] d, input logic gp);
        @(posedge clk_i);
        {msr_wr_i, msr_rd_i, msr_wdata_i} <= {wr, !wr, d};
        drop;
        check("gp_fault", gp_fault_o, gp);
    endtask : msr
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        check("vector", comm_exc_vector_o, 8'h1D);
        check("step_op", step_op_o, 4'h0);
    endtask : t_reset
    task t_host_msr;
        msr('0, '0, '1);
        msr('1, 64'h5000, '1);
    endtask : t_host_msr
    task t_enc_guest;
        enter('1, '1, '0, '0, '0, '0);
        check("save_ptr", step_addr_o, 64'h7000);
        check("full_reload", full_reload_o, 1'b1);
        // Entry steps are codes 1 to 4 in order
        for (int i = 0; i < 4; i++) check("entry_op", ops[i], i + 1);
        msr('0, '0, '0);
        check("locator_rd", msr_rdata_o, 64'h3000);
        msr('1, 64'h9000, '0);
        @(posedge clk_i);
        {exit_event_i, exit_code_i} <= {1'b1, 64'h7B};
        drop;
        check("comm_exc", comm_exc_o, 1'b1);
        check("comm_err", comm_exc_error_o, 64'h7B);
        @(posedge clk_i);
        {feat_write_i, feat_write_value_i} <= {1'b1, 64'h1000};
        drop;
        check("enable_mask", feat_wr_mask_enable_o, 1'b1);
        check("feat_val", feat_wr_o ? feat_wr_value_o : '0, 64'h1000);
        @(posedge clk_i);
        {guest_exit_insn_i, guest_rax_i, guest_cpl_i} <= {1'b1, 64'hA5A5, 2'h3};
        drop;
        check("param_wr", param_wr_o, 1'b1);
        check("param_rax", param_rax_o, 64'hA5A5);
        serve('1, '0, '0);
        // Exit steps are codes 5 to 10 in order
        for (int i = 0; i < 6; i++) check("exit_op", ops[i], i + 5);
        check("exit_code", vmexit_code_o, 64'h403);
        check("advance", advance_ip_o, 1'b1);
        check("locator_sv", vm_control_block_locator_o, 64'h9000);
    endtask : t_enc_guest
    task t_bad_entry;
        enter('1, '1, '1, '0, '0, '1);
        enter('1, '0, '0, '0, '0, '1);
        enter('1, '1, '0, 3'h4, 8'h20, '1);
        enter('1, '1, '0, 3'h3, 8'h03, '1);
        enter('1, '1, '0, 3'h3, 8'h04, '1);
    endtask : t_bad_entry
    task t_smi;
        enter('1, '1, '0, '0, '0, '0);
        @(posedge clk_i);
        {smi_i, smi_is_mc_i} <= 2'b11;
        drop;
        serve('1, '0, '0);
        check("smi_code", vmexit_code_o, 64'h62);
        check("smi_pending", smi_pending_o, 1'b1);
        @(posedge clk_i);
        gi_enable_i <= 1'b1;
        drop;
        check("smi_service", smi_service_o, 1'b1);
        check("mc_redirect", exit_info_first_o[0], 1'b1);
    endtask : t_smi
    task t_trap;
        enter('1, '1, '0, '0, '0, '0);
        @(posedge clk_i);
        {reg_write_trap_i, exit_code_i, reg_new_value_i} <= {1'b1, 64'h93, 64'h80050033};
        drop;
        serve('1, '0, '0);
        check("trap_code", vmexit_code_o, 64'h93);
        check("trap_info", exit_info_first_o, 64'h80050033);
    endtask : t_trap
    task t_plain;
        enter('0, '1, '0, '0, '0, '0);
        @(posedge clk_i);
        guest_exit_insn_i <= 1'b1;
        drop;
        check("hcall", hcall_o, 1'b1);
    endtask : t_plain
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        t_reset;
        t_host_msr;
        t_enc_guest;
        t_bad_entry;
        t_smi;
        t_trap;
        t_plain;
        finish_test;
    end
endmodule : testbench
`default_nettype wire
